// File: verilog/nbsi_pkg.sv
package nbsi_pkg;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned PWR_RECOVERY_US = 10;
    localparam int unsigned PWR_RECOVERY_CYC = (PWR_RECOVERY_US * 1000 + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int unsigned STROBE_CYC = 3;
    localparam logic [11:0] RECOV_RST = 12'h000;
    localparam logic [1:0] PHASE_RST = 2'h0;
    localparam int unsigned FIFO_DEPTH = 8;
    localparam int unsigned WORD_W = 16;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        NBSI_CMD,
        NBSI_ADDR,
        NBSI_WDATA,
        NBSI_RDATA
    } nbsi_kind_t;

    typedef struct packed {
        nbsi_kind_t kind;
        logic [15:0] word;
    } nbsi_req_t;

    typedef struct packed {
        logic [15:0] lanes_out;
        logic lanes_oe;
        logic command_capture_strobe;
        logic address_capture_strobe;
        logic chip_sel_n;
        logic write_strobe_n;
        logic read_strobe_n;
        logic write_protect_n;
    } nbsi_pins_t;
endpackage

// File: verilog/nbsi_fifo.sv
`timescale 1ns/1ps
module nbsi_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic [AW:0] cnt_nxt;
    logic ready_r;
    logic push;
    logic pop;

    // ready is registered so the upstream side sees a flop, not a compare
    assign o_in_ready = ready_r;
    assign cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    assign o_out_valid = (cnt_r != '0);
    assign o_out_data = mem_r[rp_r];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_r[wp_r] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            ready_r <= 1'b1;
        end else begin
            if (push) begin
                wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r <= cnt_nxt;
            ready_r <= (cnt_nxt != (AW+1)'(DEPTH));
        end
    end
endmodule

// File: verilog/nbsi_host.sv
`timescale 1ns/1ps
// Operation
// - low lanes carry cmd, addr, data; rising-edge capture
// - host puts cmd/addr on low lanes only
// - address strobe high: write edge loads address
// - command strobe high: write edge loads command
// - hold select low through read busy interval
// - wait 10 us after power-up before commands
module nbsi_host
    import nbsi_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_req_valid,
    output logic o_req_ready,
    input wire nbsi_pkg::nbsi_req_t i_req,
    input wire logic i_wide_bus,
    input wire logic i_allow_write,
    input wire logic i_deselect,
    output logic o_rdata_valid,
    output logic [15:0] o_rdata,
    output logic o_busy,
    output logic o_ready_link,
    output nbsi_pkg::nbsi_pins_t o_pins,
    input wire logic [15:0] i_lanes_in,
    input wire logic i_ready_busy_n
);
    import nbsi_pkg::*;

    typedef enum logic [1:0] {
        NBSI_S_RECOVER,
        NBSI_S_IDLE,
        NBSI_S_SETUP,
        NBSI_S_HOLD
    } nbsi_state_t;

    // ----------------------------------------------------------------
    // request buffer and synchronisers
    // ----------------------------------------------------------------
    logic fifo_valid;
    logic fifo_pop;
    logic [17:0] fifo_word;
    nbsi_req_t cur;

    nbsi_fifo #(.WIDTH(18), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_in_valid(i_req_valid),
        .o_in_ready(o_req_ready),
        .i_in_data(i_req),
        .o_out_valid(fifo_valid),
        .i_out_ready(fifo_pop),
        .o_out_data(fifo_word)
    );
    assign cur = nbsi_req_t'(fifo_word);

    logic rb_s1_r;
    logic rb_s2_r;
    logic [15:0] ln_s1_r;
    logic [15:0] ln_s2_r;
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            rb_s1_r <= 1'b0;
            rb_s2_r <= 1'b0;
            ln_s1_r <= '0;
            ln_s2_r <= '0;
        end else begin
            rb_s1_r <= i_ready_busy_n;
            rb_s2_r <= rb_s1_r;
            ln_s1_r <= i_lanes_in;
            ln_s2_r <= ln_s1_r;
        end
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    nbsi_state_t state_r;
    logic [11:0] recov_r;
    logic [1:0] phase_r;
    assign fifo_pop = (state_r == NBSI_S_HOLD) && (phase_r == 2'(STROBE_CYC - 1));

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state_r <= NBSI_S_RECOVER;
            recov_r <= RECOV_RST;
            phase_r <= PHASE_RST;
        end else begin
            unique case (state_r)
                NBSI_S_RECOVER: begin
                    // no command until power recovery has elapsed
                    // counter saturates so a long busy never wraps it
                    if (recov_r < 12'(PWR_RECOVERY_CYC - 1)) begin
                        recov_r <= recov_r + 12'h001;
                    end
                    if (recov_r >= 12'(PWR_RECOVERY_CYC - 1) && rb_s2_r) begin
                        state_r <= NBSI_S_IDLE;
                    end
                end
                NBSI_S_IDLE: begin
                    phase_r <= PHASE_RST;
                    if (fifo_valid && rb_s2_r) begin
                        state_r <= NBSI_S_SETUP;
                    end
                end
                NBSI_S_SETUP: begin
                    phase_r <= phase_r + 2'h1;
                    if (phase_r == 2'(STROBE_CYC - 1)) begin
                        phase_r <= PHASE_RST;
                        state_r <= NBSI_S_HOLD;
                    end
                end
                NBSI_S_HOLD: begin
                    phase_r <= phase_r + 2'h1;
                    if (fifo_pop) begin
                        phase_r <= PHASE_RST;
                        state_r <= NBSI_S_IDLE;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // pin drive
    // ----------------------------------------------------------------
    logic act;
    assign act = (state_r == NBSI_S_SETUP) || (state_r == NBSI_S_HOLD);

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_pins <= '{lanes_out: 16'h0000, lanes_oe: 1'b0, command_capture_strobe: 1'b0,
                        address_capture_strobe: 1'b0, chip_sel_n: 1'b1,
                        write_strobe_n: 1'b1, read_strobe_n: 1'b1, write_protect_n: 1'b0};
        end else begin
            o_pins.write_protect_n <= i_allow_write && state_r != NBSI_S_RECOVER;
            // select held low while busy so reads are never aborted
            o_pins.chip_sel_n <= i_deselect && rb_s2_r && !act;
            o_pins.command_capture_strobe <= act && cur.kind == NBSI_CMD;
            o_pins.address_capture_strobe <= act && cur.kind == NBSI_ADDR;
            o_pins.lanes_oe <= act && cur.kind != NBSI_RDATA;
            if (cur.kind == NBSI_CMD || cur.kind == NBSI_ADDR || !i_wide_bus) begin
                o_pins.lanes_out <= {8'h00, cur.word[7:0]};
            end else begin
                o_pins.lanes_out <= cur.word;
            end
            // write edge rises one cycle after setup->hold, the memory captures then
            o_pins.write_strobe_n <= !(state_r == NBSI_S_SETUP && cur.kind != NBSI_RDATA);
            o_pins.read_strobe_n <= !(state_r == NBSI_S_SETUP && cur.kind == NBSI_RDATA);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_rdata_valid <= 1'b0;
            o_rdata <= '0;
            o_busy <= 1'b1;
            o_ready_link <= 1'b0;
        end else begin
            o_rdata_valid <= fifo_pop && cur.kind == NBSI_RDATA;
            if (fifo_pop && cur.kind == NBSI_RDATA) begin
                o_rdata <= i_wide_bus ? ln_s2_r : {8'h00, ln_s2_r[7:0]};
            end
            o_busy <= state_r != NBSI_S_IDLE || !rb_s2_r;
            o_ready_link <= rb_s2_r;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_no_dual_strobe;
        @(posedge i_clk) disable iff (i_sys_rst)
        !(o_pins.command_capture_strobe && o_pins.address_capture_strobe);
    endproperty
    a_no_dual_strobe: assert property (p_no_dual_strobe) else $error("both strobes high");

    property p_cmd_low_only;
        @(posedge i_clk) disable iff (i_sys_rst)
        (o_pins.command_capture_strobe || o_pins.address_capture_strobe)
            |-> o_pins.lanes_out[15:8] == 8'h00;
    endproperty
    a_cmd_low_only: assert property (p_cmd_low_only) else $error("cmd on upper lanes");

    property p_no_early_cmd;
        @(posedge i_clk) disable iff (i_sys_rst)
        state_r == NBSI_S_RECOVER |-> o_pins.write_strobe_n && o_pins.read_strobe_n;
    endproperty
    a_no_early_cmd: assert property (p_no_early_cmd) else $error("strobe in recovery");

    property p_hold_sel_busy;
        @(posedge i_clk) disable iff (i_sys_rst)
        (!rb_s2_r && !o_pins.chip_sel_n) |=> !o_pins.chip_sel_n;
    endproperty
    a_hold_sel_busy: assert property (p_hold_sel_busy) else $error("select raised busy");

    sequence s_setup;
        state_r == NBSI_S_SETUP && cur.kind != NBSI_RDATA && phase_r == 2'h0;
    endsequence
    property p_write_edge;
        @(posedge i_clk) disable iff (i_sys_rst)
        s_setup |=> !o_pins.write_strobe_n [*3] ##1 o_pins.write_strobe_n;
    endproperty
    a_write_edge: assert property (p_write_edge) else $error("write strobe shape");

    property p_wp_recover;
        @(posedge i_clk) disable iff (i_sys_rst)
        state_r == NBSI_S_RECOVER |=> !o_pins.write_protect_n;
    endproperty
    a_wp_recover: assert property (p_wp_recover) else $error("write enabled early");

    property p_rd_no_drive;
        @(posedge i_clk) disable iff (i_sys_rst)
        !o_pins.read_strobe_n |-> !o_pins.lanes_oe;
    endproperty
    a_rd_no_drive: assert property (p_rd_no_drive) else $error("drive during read");

    property p_addr_strobe;
        @(posedge i_clk) disable iff (i_sys_rst)
        (state_r == NBSI_S_SETUP && cur.kind == NBSI_ADDR) |=> o_pins.address_capture_strobe;
    endproperty
    a_addr_strobe: assert property (p_addr_strobe) else $error("address strobe low");
endmodule

// File: tb/nbsi_mem_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// behavioural memory at the pins
// ----------------------------------------
module nbsi_mem_model
    import nbsi_pkg::*;
(
    input wire nbsi_pkg::nbsi_pins_t i_pins,
    input wire logic i_hold_busy,
    output logic [15:0] o_lanes,
    output logic o_ready_busy_n
);
    nbsi_kind_t cap_kind [64];
    logic [15:0] cap_word [64];
    logic cap_wp [64];
    int cap_cnt = 0;
    int viol_cnt = 0;
    realtime first_cap = 0.0;
    logic [15:0] col_r = 16'hc3a0;
    logic [15:0] last_r = 16'h0000;
    logic drive_r = 1'b0;
    logic recov_r = 1'b0;
    logic ctl;
    assign ctl = i_pins.command_capture_strobe || i_pins.address_capture_strobe;
    initial #10us recov_r = 1'b1;
    // busy runs on whatever select does, so a select rise never ends it
    assign o_ready_busy_n = recov_r && !i_hold_busy;
    // released lanes show the inverse of the last word, never a stale copy
    assign o_lanes = (drive_r && !i_pins.chip_sel_n) ? last_r : ~last_r;
    always @(posedge i_pins.write_strobe_n) begin
        if (i_pins.chip_sel_n === 1'b0) begin
            if (cap_cnt == 0)
                first_cap = $realtime;
            if (i_pins.command_capture_strobe && i_pins.address_capture_strobe)
                viol_cnt++;
            if (!o_ready_busy_n || (ctl && i_pins.lanes_out[15:8] != 8'h00))
                viol_cnt++;
            cap_kind[cap_cnt] = i_pins.command_capture_strobe ? NBSI_CMD :
                (i_pins.address_capture_strobe ? NBSI_ADDR : NBSI_WDATA);
            cap_word[cap_cnt] = i_pins.lanes_out;
            // protect level kept per word: a low level means program is refused
            cap_wp[cap_cnt] = i_pins.write_protect_n;
            cap_cnt++;
        end
    end
    always @(negedge i_pins.write_strobe_n)
        drive_r = 1'b0;
    always @(negedge i_pins.read_strobe_n) begin
        if (i_pins.chip_sel_n === 1'b0) begin
            last_r = col_r;
            col_r++;
            drive_r = 1'b1;
        end
    end
endmodule

// File: tb/nbsi_host_tb_top.sv
`timescale 1ns/1ps
module nbsi_host_tb_top;
    import nbsi_pkg::*;
    logic i_clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    nbsi_req_t req = '0;
    logic wide = 1'b1;
    logic allow_w = 1'b0;
    logic desel = 1'b0;
    logic hold_busy = 1'b0;
    logic rd_valid, busy, ready_link, req_ready, rb_n;
    logic [15:0] rdata, lanes_in, mem_lanes;
    nbsi_pins_t pins;
    int err_total = 0;
    int num_checks = 0;
    always #5 i_clk = ~i_clk;
    assign lanes_in = pins.lanes_oe ? pins.lanes_out : mem_lanes;
    nbsi_host dut (.i_clk(i_clk), .i_sys_rst(rst), .i_req_valid(req_valid),
        .o_req_ready(req_ready), .i_req(req), .i_wide_bus(wide), .i_allow_write(allow_w),
        .i_deselect(desel), .o_rdata_valid(rd_valid), .o_rdata(rdata), .o_busy(busy),
        .o_ready_link(ready_link), .o_pins(pins), .i_lanes_in(lanes_in),
        .i_ready_busy_n(rb_n));
    nbsi_mem_model mem (.i_pins(pins), .i_hold_busy(hold_busy), .o_lanes(mem_lanes),
        .o_ready_busy_n(rb_n));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks=%0d errors=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic push(input nbsi_kind_t kind, input logic [15:0] word);
        int n = 0;
        req_valid <= 1'b1;
        req <= '{kind: kind, word: word};
        do begin
            @(posedge i_clk);
            n++;
        end while (req_ready !== 1'b1 && n < 50);
        chk({15'h0, req_ready}, 16'h0001);
    endtask
    task automatic stop();
        req_valid <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic wait_caps(input int n);
        int c = 0;
        while (mem.cap_cnt < n && c < 3000) begin
            @(posedge i_clk);
            c++;
        end
        chk(16'(mem.cap_cnt), 16'(n));
    endtask
    task automatic cap(input int i, input nbsi_kind_t kind, input logic [15:0] word);
        chk(16'(mem.cap_kind[i]), 16'(kind));
        chk(mem.cap_word[i], word);
    endtask
    task automatic rd(input logic [15:0] exp);
        int c = 0;
        push(NBSI_RDATA, 16'h0000);
        stop();
        while (rd_valid !== 1'b1 && c < 100) begin
            @(posedge i_clk);
            c++;
        end
        chk(wide ? rdata : {8'h00, rdata[7:0]}, exp);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        chk({10'h0, pins.chip_sel_n, pins.lanes_oe, pins.write_protect_n,
            pins.write_strobe_n, pins.read_strobe_n, busy}, 16'h0027);
    endtask
    task automatic t_boot();
        push(NBSI_CMD, 16'hab90);
        stop();
        wait_caps(1);
        cap(0, NBSI_CMD, 16'h0090);
        chk({15'h0, mem.first_cap >= 10000.0}, 16'h0001);
    endtask
    task automatic t_seq();
        push(NBSI_ADDR, 16'h5a3c);
        push(NBSI_WDATA, 16'hbeef);
        stop();
        wait_caps(3);
        cap(1, NBSI_ADDR, 16'h003c);
        cap(2, NBSI_WDATA, 16'hbeef);
        wide <= 1'b0;
        push(NBSI_WDATA, 16'h1234);
        stop();
        wait_caps(4);
        chk({8'h00, mem.cap_word[3][7:0]}, 16'h0034);
        rd(16'h00a0);
        wide <= 1'b1;
        rd(16'hc3a1);
    endtask
    task automatic t_fifo();
        hold_busy <= 1'b1;
        desel <= 1'b1;
        repeat (6) @(posedge i_clk);
        chk({14'h0, ready_link, busy}, 16'h0001);
        for (int k = 0; k < 8; k++)
            push(NBSI_WDATA, 16'h7100 + 16'(k));
        stop();
        chk({14'h0, req_ready, pins.chip_sel_n}, 16'h0000);
        chk(16'(mem.cap_cnt), 16'h0004);
        hold_busy <= 1'b0;
        wait_caps(12);
        for (int k = 0; k < 8; k++)
            cap(4 + k, NBSI_WDATA, 16'h7100 + 16'(k));
        repeat (10) @(posedge i_clk);
        chk({14'h0, pins.chip_sel_n, pins.lanes_oe}, 16'h0002);
        desel <= 1'b0;
    endtask
    task automatic t_wp();
        allow_w <= 1'b1;
        repeat (3) @(posedge i_clk);
        chk({15'h0, pins.write_protect_n}, 16'h0001);
        push(NBSI_WDATA, 16'h0d0e);
        stop();
        wait_caps(13);
        cap(12, NBSI_WDATA, 16'h0d0e);
        chk({15'h0, mem.cap_wp[12]}, 16'h0001);
        chk({15'h0, mem.cap_wp[11]}, 16'h0000);
        allow_w <= 1'b0;
        repeat (3) @(posedge i_clk);
        chk({15'h0, pins.write_protect_n}, 16'h0000);
    endtask
    initial begin
        repeat (3) @(posedge i_clk);
        rst <= 1'b0;
        @(posedge i_clk);
        t_reset();
        t_boot();
        t_seq();
        t_fifo();
        t_wp();
        chk(16'(mem.viol_cnt), 16'h0000);
        give_verdict();
    end
    initial begin
        #100us;
        err_total++;
        give_verdict();
    end
endmodule
